// ===== logic/svm_consts.svh
// Offsets, field positions and reset values of the supply monitor.
`ifndef SVM_CONSTS_SVH
`define SVM_CONSTS_SVH

`define SVM_OFF_CONTROL 4'h0
`define SVM_OFF_IRQ_STATUS 4'h4
`define SVM_OFF_IRQ_MASK 4'h8
`define SVM_OFF_SYSTEM 4'hc

`define SVM_CTL_TRIP_LSB 0
`define SVM_CTL_TRIP_MSB 3
`define SVM_CTL_POWER_BIT 4
`define SVM_CTL_STABLE_BIT 5

`define SVM_TRIP_RESET 4'h5
`define SVM_TRIP_EXTERNAL 4'hf
`define SVM_TRIP_RESERVED 4'h0

`define SVM_IRQ_UNDERVOLT_BIT 0
`define SVM_IRQ_STABLE_BIT 1
`define SVM_IRQ_WIDTH 2
`define SVM_IRQ_RESET 2'h0

`define SVM_SYS_GIE_BIT 0
`define SVM_SYS_SLEEP_BIT 1

`endif

// ===== logic/svm_pkg.sv
// Types of the supply monitor.
package svm_pkg;

    typedef struct packed {
        logic [1:0] comp_sync;
        logic [1:0] ready_sync;
        logic [1:0] bor_sync;
        logic [3:0] trip_level_select;
        logic monitor_power_enable;
        logic reference_stable;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic global_irq_enable;
        logic ack;
        logic waitrequest;
        logic [31:0] readdata;
        logic irq;
        logic vector_redirect;
        logic wake_req;
        logic analog_power_on;
        logic reference_power_on;
        logic [3:0] tap_select;
        logic use_external_input;
    } svm_state_t;

endpackage : svm_pkg

// ===== logic/svm_top.sv
// Digital control and flag logic of the supply undervoltage monitor.
//
// Behaviour
// (RL1) Comparator below reference sets undervoltage flag.
// (RL2) Enabled flag redirects execution to interrupt vector.
// (RL3) Four-bit trip select in control bits 3-0.
// (RL4) Code all-ones routes external input to comparator.
// (RL5) Codes 0001-1110 rising levels; 0000 reserved.
// (RL6) Control bit 4 powers monitor up or down.
// (RL7) Control bit 5 reads reference stable, read-only.
// (RL8) Control bits 7-6 read zero, ignore writes.
// (RL9) Reset: monitor off, trip select 0101.
// (RL10) No valid indication before reference is stable.
// (RL11) Start-up delay is time, not clock count.
// (RL12) Reference shared with brown-out reset circuit.
// (RL13) Flag may set spuriously while stabilising.
// (RL14) Software: code, irq off, enable, wait, clear.
// (RL15) Monitor works in sleep; flag wakes device.
// (RL16) Wake goes to vector only if globally enabled.
// (RL17) Comparator and ready inputs pass two flip-flops.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "svm_consts.svh"

module svm_top (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Avalon-MM slave.
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Analog front end.
    input wire logic comp_below,
    input wire logic reference_ready,
    input wire logic bor_reference_active,
    output logic analog_power_on,
    output logic reference_power_on,
    output logic [3:0] tap_select,
    output logic use_external_input,
    // Core side.
    input wire logic sleep_mode,
    output logic irq,
    output logic vector_redirect,
    output logic wake_req
);

    svm_pkg::svm_state_t st;
    svm_pkg::svm_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic access;
        logic [1:0] set_ev;
        logic [1:0] clr_ev;
        logic [1:0] pending;
        logic stable_now;
        access = 1'b0;
        set_ev = 2'h0;
        clr_ev = 2'h0;
        pending = 2'h0;
        stable_now = 1'b0;
        next_st = st;

        // Asynchronous analog levels pass two flip-flops first.
        next_st.comp_sync = {st.comp_sync[0], comp_below}; // see (RL17)
        next_st.ready_sync = {st.ready_sync[0], reference_ready}; // see (RL17)
        next_st.bor_sync = {st.bor_sync[0], bor_reference_active};

        // Stability comes from the analog ready level, so the start-up
        // time holds at any clock rate; a reference kept alive by the
        // brown-out circuit is already ready and gives no delay.
        stable_now = st.monitor_power_enable & st.ready_sync[1]; // see (RL11)
        next_st.reference_stable = stable_now; // see (RL10)

        // Bus access completes one cycle after the request is seen.
        access = (read | write) & ~st.ack;
        next_st.ack = access;
        next_st.waitrequest = ~access;

        // The comparator may trip during settling; software clears it.
        if (st.monitor_power_enable && st.comp_sync[1]) begin
            set_ev[`SVM_IRQ_UNDERVOLT_BIT] = 1'b1; // see (RL1) (RL13)
        end
        if (stable_now && !st.reference_stable) begin
            set_ev[`SVM_IRQ_STABLE_BIT] = 1'b1;
        end

        if (access && read) begin
            next_st.readdata = 32'h0;
            unique case (address)
                `SVM_OFF_CONTROL: begin
                    // Bits 7-6 stay zero.
                    next_st.readdata[`SVM_CTL_TRIP_MSB:`SVM_CTL_TRIP_LSB] =
                        st.trip_level_select; // see (RL8)
                    next_st.readdata[`SVM_CTL_POWER_BIT] =
                        st.monitor_power_enable;
                    next_st.readdata[`SVM_CTL_STABLE_BIT] =
                        st.reference_stable; // see (RL7)
                end
                `SVM_OFF_IRQ_STATUS: begin
                    next_st.readdata[`SVM_IRQ_WIDTH-1:0] = st.irq_status;
                end
                `SVM_OFF_IRQ_MASK: begin
                    next_st.readdata[`SVM_IRQ_WIDTH-1:0] = st.irq_mask;
                end
                `SVM_OFF_SYSTEM: begin
                    next_st.readdata[`SVM_SYS_GIE_BIT] = st.global_irq_enable;
                    next_st.readdata[`SVM_SYS_SLEEP_BIT] = sleep_mode;
                end
                default: begin
                    next_st.readdata = 32'h0;
                end
            endcase
        end

        if (access && write && byteenable[0]) begin
            unique case (address)
                `SVM_OFF_CONTROL: begin
                    next_st.trip_level_select =
                        writedata[`SVM_CTL_TRIP_MSB:`SVM_CTL_TRIP_LSB]; // see (RL3)
                    next_st.monitor_power_enable =
                        writedata[`SVM_CTL_POWER_BIT]; // see (RL6)
                end
                `SVM_OFF_IRQ_STATUS: begin
                    clr_ev = writedata[`SVM_IRQ_WIDTH-1:0];
                end
                `SVM_OFF_IRQ_MASK: begin
                    next_st.irq_mask = writedata[`SVM_IRQ_WIDTH-1:0];
                end
                `SVM_OFF_SYSTEM: begin
                    next_st.global_irq_enable = writedata[`SVM_SYS_GIE_BIT];
                end
                default: begin
                end
            endcase
        end

        // A new event wins over a clear in the same cycle.
        next_st.irq_status = (st.irq_status & ~clr_ev) | set_ev;

        pending = next_st.irq_status & next_st.irq_mask;
        next_st.irq = |pending;
        next_st.vector_redirect = (|pending) &
            next_st.global_irq_enable; // see (RL2) (RL16)
        next_st.wake_req = sleep_mode & (|pending); // see (RL15)

        // The front end keeps running in sleep while enabled.
        next_st.analog_power_on = next_st.monitor_power_enable; // see (RL15)
        next_st.reference_power_on = next_st.monitor_power_enable |
            st.bor_sync[1]; // see (RL12)
        // The reserved code goes to tap_select unchanged; the external code selects the pin.
        next_st.use_external_input = next_st.trip_level_select ==
            `SVM_TRIP_EXTERNAL; // see (RL4)
        next_st.tap_select = next_st.trip_level_select; // see (RL5)
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.trip_level_select <= `SVM_TRIP_RESET; // see (RL9)
            st.tap_select <= `SVM_TRIP_RESET;
            st.irq_status <= `SVM_IRQ_RESET;
            st.irq_mask <= `SVM_IRQ_RESET;
            st.waitrequest <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign analog_power_on = st.analog_power_on;
    assign reference_power_on = st.reference_power_on;
    assign tap_select = st.tap_select;
    assign use_external_input = st.use_external_input;
    assign irq = st.irq;
    assign vector_redirect = st.vector_redirect;
    assign wake_req = st.wake_req;

endmodule : svm_top
`default_nettype wire

// ===== tb/svm_chk.sv
// Port assertions of the supply monitor.
`timescale 1ns/1ps
`default_nettype none
module svm_chk (
    // Monitor ports.
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic analog_power_on,
    input wire logic reference_power_on,
    input wire logic [3:0] tap_select,
    input wire logic use_external_input,
    input wire logic sleep_mode,
    input wire logic irq,
    input wire logic vector_redirect,
    input wire logic wake_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_reset_state: assert property (
        $fell(sys_rst) |-> tap_select == 4'h5 && !analog_power_on)
        else $error("Reset state wrong.");
    chk_ext_route: assert property (
        use_external_input == (tap_select == 4'hf))
        else $error("External input routing wrong.");
    chk_tap_write: assert property (
        $changed(tap_select) |-> $past(write && waitrequest))
        else $error("Trip select changed without a write.");
    chk_ctl_upper: assert property (
        read && !waitrequest && address == 4'h0 |-> readdata[31:6] == 26'h0)
        else $error("Control upper bits not zero.");
    chk_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("Bus answer timing wrong.");
    chk_ref_shared: assert property (
        analog_power_on && $past(analog_power_on) |-> reference_power_on)
        else $error("Reference off while monitor on.");
    chk_vector_gate: assert property (
        vector_redirect |-> irq || $past(irq))
        else $error("Vector redirect without interrupt.");
    chk_wake_sleep: assert property (
        wake_req |-> sleep_mode || $past(sleep_mode))
        else $error("Wake request outside sleep.");
endmodule : svm_chk
bind svm_top svm_chk chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .analog_power_on(analog_power_on),
    .reference_power_on(reference_power_on), .tap_select(tap_select),
    .use_external_input(use_external_input), .sleep_mode(sleep_mode),
    .irq(irq), .vector_redirect(vector_redirect), .wake_req(wake_req));
`default_nettype wire

// ===== tb/test_supply_undervoltage_monitor.sv
// Self-checking testbench of the supply monitor.
`timescale 1ns/1ps
`default_nettype none
module test_supply_undervoltage_monitor;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic comp_below = 1'b0;
    logic reference_ready = 1'b0;
    logic bor_reference_active = 1'b0;
    logic sleep_mode = 1'b0;
    logic [31:0] readdata, q;
    logic waitrequest, analog_power_on, reference_power_on, irq;
    logic use_external_input, vector_redirect, wake_req;
    logic [3:0] tap_select;
    int error_cnt = 0;
    int tests_run = 0;
    always #50 core_clk = ~core_clk;
    svm_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
        .comp_below(comp_below), .reference_ready(reference_ready),
        .bor_reference_active(bor_reference_active),
        .analog_power_on(analog_power_on),
        .reference_power_on(reference_power_on), .tap_select(tap_select),
        .use_external_input(use_external_input), .sleep_mode(sleep_mode),
        .irq(irq), .vector_redirect(vector_redirect), .wake_req(wake_req));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input int d);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= 32'(d);
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic t_reset;
        bus(0, 4'h0, 0);
        chk(q, 32'h5);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        for (int c = 1; c < 16; c++) begin
            bus(1, 4'h0, 32'he0 | c);
            bus(0, 4'h0, 0);
            chk(q, 32'(c));
            chk(tap_select, 32'(c));
            chk(use_external_input, 32'(c == 15));
        end
        $display("reset and trip test done");
    endtask : t_reset
    task automatic t_flag;
        bus(1, 4'h8, 0);
        bus(1, 4'h0, 32'h13);
        chk(analog_power_on, 1);
        reference_ready <= 1'b1;
        q = 0;
        for (int i = 0; i < 20 && q[5] !== 1'b1; i++) bus(0, 4'h0, 0);
        chk(q, 32'h33);
        bus(1, 4'h4, 32'h3);
        comp_below <= 1'b1;
        repeat (6) @(posedge core_clk);
        bus(0, 4'h4, 0);
        chk(q[0], 1);
        chk(irq, 0);
        bus(1, 4'h8, 32'h1);
        repeat (3) @(posedge core_clk);
        chk({irq, vector_redirect}, 2'h2);
        bus(1, 4'hc, 32'h1);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({vector_redirect, wake_req}, 2'h3);
        comp_below <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk({analog_power_on, irq, tap_select}, 6'h05);
        $display("flag test done");
    endtask : t_flag
    task automatic t_power;
        bor_reference_active <= 1'b1;
        comp_below <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(reference_power_on, 1);
        bus(0, 4'h0, 0);
        chk(q, 32'h5);
        bus(0, 4'h4, 0);
        chk(q[0], 0);
        $display("power test done");
    endtask : t_power
    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_flag();
        t_power();
        summarize();
    end
endmodule : test_supply_undervoltage_monitor
`default_nettype wire
